// ==== hdl/ltic_decide.sv ====
// ltic_decide: per-frame classification decision, registered once.
// assumes frame header facts arrive as one-cycle strobed inputs.
`timescale 1ns/1ps
module ltic_decide (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic frm_valid_in,
    input wire logic [2:0] frm_port_in,
    input wire logic [2:0] frm_class_in,
    input wire logic frm_has_l3_l4_in,
    input wire logic typ_match_in,
    input wire logic prot_match_in,
    input wire logic dst_match_in,
    input wire logic src_match_in,
    input wire logic [1:0] dst_queue_in,
    input wire logic [1:0] src_queue_in,
    input wire logic [15:0] l4_ctrl_in,
    input wire logic [15:0] tag_ctrl_in,
    output logic dec_valid_out,
    output logic dec_tag_out,
    output logic dec_l4_match_out,
    output logic dec_use_l3_out,
    output logic dec_prio_valid_out,
    output logic [1:0] dec_queue_out
);
    // ========================================================
    // combinational decision
    logic [1:0] comp;
    logic l4_hit;
    logic [1:0] l4_queue;
    logic use_l3;
    logic tag;
    logic prio_en;
    assign comp = l4_ctrl_in[ltic_pkg::COMP_LSB +: 2];

    // l4 comparison by mode
    always_comb begin
        l4_hit = 1'b0;
        l4_queue = dst_queue_in;
        case (comp) // see [R1]
            ltic_pkg::COMP_NONE: l4_hit = 1'b0;
            ltic_pkg::COMP_DST: l4_hit = dst_match_in;
            ltic_pkg::COMP_SRC: begin
                l4_hit = src_match_in;
                l4_queue = src_queue_in;
            end
            ltic_pkg::COMP_EITHER: begin
                l4_hit = dst_match_in | src_match_in;
                l4_queue = dst_match_in ? dst_queue_in : src_queue_in;
            end
            default: l4_hit = 1'b0;
        endcase
    end

    // per port source select and priority enable
    always_comb begin
        use_l3 = 1'b0;
        prio_en = 1'b0;
        if (frm_port_in < 3'(ltic_pkg::NUM_PORTS)) begin
            use_l3 = frm_has_l3_l4_in & l4_ctrl_in[ltic_pkg::L3_SEL_LSB + frm_port_in]; // see [R2]
            prio_en = l4_ctrl_in[ltic_pkg::PRIO_EN_LSB + frm_port_in]; // see [R3]
        end
    end

    // tag decision; reserved bit 7 has no effect
    always_comb begin
        tag = 1'b0;
        if (typ_match_in) begin
            tag = tag_ctrl_in[ltic_pkg::TAG_ON_ETHERTYPE_MATCH_BIT]; // see [R8]
        end else if (prot_match_in) begin
            tag = tag_ctrl_in[ltic_pkg::TAG_ON_L3_PROTO_MATCH_BIT]; // see [R9]
        end else if (l4_hit) begin
            tag = tag_ctrl_in[ltic_pkg::TAG_ON_L4_PORT_MATCH_BIT]; // see [R10]
        end else begin
            case (frm_class_in)
                3'(ltic_pkg::LTIC_CLS_IP): tag = tag_ctrl_in[ltic_pkg::TAG_ON_INTERNET_PROTO_FRAMES_BIT]; // see [R5]
                3'(ltic_pkg::LTIC_CLS_ARP): tag = tag_ctrl_in[ltic_pkg::TAG_ON_ADDR_RESOLUTION_BIT]; // see [R6]
                3'(ltic_pkg::LTIC_CLS_SNOOP): tag = tag_ctrl_in[ltic_pkg::TAG_ON_MULTICAST_CTRL_BIT]; // see [R7]
                3'(ltic_pkg::LTIC_CLS_MACCTRL): tag = tag_ctrl_in[ltic_pkg::TAG_ON_FLOW_CTRL_FRAMES_BIT]; // see [R11]
                default: tag = tag_ctrl_in[ltic_pkg::TAG_ON_OTHER_FRAMES_BIT]; // see [R12]
            endcase
        end
    end

    // registered decision outputs
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dec_valid_out <= 1'b0;
            dec_tag_out <= 1'b0;
            dec_l4_match_out <= 1'b0;
            dec_use_l3_out <= 1'b0;
            dec_prio_valid_out <= 1'b0;
            dec_queue_out <= 2'h0;
        end else begin
            dec_valid_out <= frm_valid_in;
            dec_tag_out <= frm_valid_in & tag;
            dec_l4_match_out <= frm_valid_in & l4_hit;
            dec_use_l3_out <= frm_valid_in & use_l3;
            // queue from filter only when enabled and not overridden
            dec_prio_valid_out <= frm_valid_in & l4_hit & prio_en & ~use_l3; // see [R3]
            dec_queue_out <= (l4_hit & prio_en & ~use_l3) ? l4_queue : 2'h0; // see [R14]
        end
    end
endmodule // ltic_decide

// ==== hdl/ltic_pkg.sv ====
// ltic_pkg: register map, field positions and reset values of the
// l4 match / tag insert control block.
// assumes a 32-bit axi4-lite register bus with word-aligned registers.
package ltic_pkg;
    // ========================================================
    // register indices and byte addresses
    localparam logic [7:0] L4_MATCH_PORT_CTRL_IDX = 8'h98;
    localparam logic [7:0] TAG_INSERT_CTRL_IDX = 8'h99;
    localparam logic [7:0] SEC_STATUS_IDX = 8'h9a;
    localparam logic [9:0] L4_MATCH_PORT_CTRL_ADDR = {L4_MATCH_PORT_CTRL_IDX, 2'b00};
    localparam logic [9:0] TAG_INSERT_CTRL_ADDR = {TAG_INSERT_CTRL_IDX, 2'b00};
    localparam logic [9:0] SEC_STATUS_ADDR = {SEC_STATUS_IDX, 2'b00};
    // ========================================================
    // reset values and l4 write mask
    localparam logic [15:0] L4_MATCH_PORT_CTRL_RST = 16'h0000;
    localparam logic [15:0] TAG_INSERT_CTRL_RST = 16'h01ff;
    localparam logic [15:0] L4_MATCH_WR_MASK = 16'h3fff;
    // ========================================================
    // field positions and port count
    localparam int COMP_LSB = 12;
    localparam int L3_SEL_LSB = 6;
    localparam int PRIO_EN_LSB = 0;
    localparam int ADDR_CHG_BIT = 9;
    localparam int TAG_ON_INTERNET_PROTO_FRAMES_BIT = 8;
    localparam int TAG_RESERVED_BIT_BIT = 7;
    localparam int TAG_ON_ADDR_RESOLUTION_BIT = 6;
    localparam int TAG_ON_MULTICAST_CTRL_BIT = 5;
    localparam int TAG_ON_ETHERTYPE_MATCH_BIT = 4;
    localparam int TAG_ON_L3_PROTO_MATCH_BIT = 3;
    localparam int TAG_ON_L4_PORT_MATCH_BIT = 2;
    localparam int TAG_ON_FLOW_CTRL_FRAMES_BIT = 1;
    localparam int TAG_ON_OTHER_FRAMES_BIT = 0;
    localparam int NUM_PORTS = 6;
    // ========================================================
    // compare modes and bus responses
    localparam logic [1:0] COMP_NONE = 2'h0;
    localparam logic [1:0] COMP_DST = 2'h1;
    localparam logic [1:0] COMP_SRC = 2'h2;
    localparam logic [1:0] COMP_EITHER = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // frame classes
    typedef enum logic [2:0] {
        LTIC_CLS_OTHER,
        LTIC_CLS_IP,
        LTIC_CLS_ARP,
        LTIC_CLS_SNOOP,
        LTIC_CLS_MACCTRL
    } ltic_class_t;
endpackage

// ==== hdl/ltic_top.sv ====
// ltic_top: l4 match / special tag insert control with axi4-lite registers.
// assumes one 20 mhz clock, frame facts and address-change events synchronous.
// Contract
// [R1] the two-bit compare field picks none, destination, source, or either port.
// [R2] per port, a set select bit uses the ip field for frames with ip and l4 headers.
// [R3] per port, an enable bit lets l4 filter priority apply; clear ignores it.
// [R4] the address-change include bit makes address changes a security event.
// [R5] the ip insert bit tags ip frames not matched by type, protocol or port rules.
// [R6] the arp insert bit tags arp and rarp frames.
// [R7] the snoop insert bit tags igmp and mld frames.
// [R8] the type insert bit tags frames matching a type filter.
// [R9] the protocol insert bit tags frames matching a protocol filter.
// [R10] the l4 port insert bit tags frames matching a port filter.
// [R11] the mac control insert bit tags mac control frames.
// [R12] the default insert bit tags every frame outside the other classes.
// [R13] after reset all nine insert bits are set and the include bit is clear.
// [R14] the l4 filter priority is a two-bit queue number 0 to 3.
// [R15] a per-port violation bit latches high and clears when read.
// [R16] reserved insert bit 7 is stored and read back with no effect.
// [R17] the top two bits of the l4 control register read zero and ignore writes.
`timescale 1ns/1ps
module ltic_top (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // axi4-lite slave
    input wire logic [9:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [9:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // frame facts from the parser
    input wire logic frm_valid_in,
    input wire logic [2:0] frm_port_in,
    input wire logic [2:0] frm_class_in,
    input wire logic frm_has_l3_l4_in,
    input wire logic typ_match_in,
    input wire logic prot_match_in,
    input wire logic dst_match_in,
    input wire logic src_match_in,
    input wire logic [1:0] dst_queue_in,
    input wire logic [1:0] src_queue_in,
    // security events per port
    input wire logic [5:0] addr_change_in,
    input wire logic [5:0] violation_in,
    // decisions
    output logic dec_valid_out,
    output logic dec_tag_out,
    output logic dec_l4_match_out,
    output logic dec_use_l3_out,
    output logic dec_prio_valid_out,
    output logic [1:0] dec_queue_out,
    output logic [5:0] security_violation_flag_out
);
    // ========================================================
    // register state
    logic [15:0] l4_match_port_ctrl_reg;
    logic [15:0] tag_insert_ctrl_reg;
    logic [5:0] sec_flag_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [9:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;
    logic rd_fire;
    logic sec_rd_clear;
    logic [5:0] sec_set;

    // merge a 16-bit register with byte strobes
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0] st);
        merge16 = old_v;
        if (st[0]) begin
            merge16[7:0] = wd[7:0];
        end
        if (st[1]) begin
            merge16[15:8] = wd[15:8];
        end
    endfunction

    // known register word addresses
    function automatic logic addr_known(input logic [9:0] a);
        addr_known = (a[9:2] == ltic_pkg::L4_MATCH_PORT_CTRL_IDX) ||
                     (a[9:2] == ltic_pkg::TAG_INSERT_CTRL_IDX) ||
                     (a[9:2] == ltic_pkg::SEC_STATUS_IDX);
    endfunction

    // ========================================================
    // write channel capture, address and data in any order
    assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid_out;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= 10'h000;
            s_axi_awready_out <= 1'b0;
        end else begin
            s_axi_awready_out <= 1'b0;
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end else if (s_axi_awvalid_in & s_axi_awready_out) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr_in;
            end else if (s_axi_awvalid_in & ~aw_held_reg) begin
                s_axi_awready_out <= 1'b1;
            end
        end
    end

    // write data capture
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            w_held_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_wready_out <= 1'b0;
        end else begin
            s_axi_wready_out <= 1'b0;
            if (wr_fire) begin
                w_held_reg <= 1'b0;
            end else if (s_axi_wvalid_in & s_axi_wready_out) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata_in;
                wstrb_reg <= s_axi_wstrb_in;
            end else if (s_axi_wvalid_in & ~w_held_reg) begin
                s_axi_wready_out <= 1'b1;
            end
        end
    end

    // write response
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= ltic_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= addr_known(awaddr_reg) ? ltic_pkg::RESP_OKAY
                                                       : ltic_pkg::RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // ========================================================
    // control registers
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            l4_match_port_ctrl_reg <= ltic_pkg::L4_MATCH_PORT_CTRL_RST;
            tag_insert_ctrl_reg <= ltic_pkg::TAG_INSERT_CTRL_RST; // see [R13]
        end else if (wr_fire) begin
            if (awaddr_reg[9:2] == ltic_pkg::L4_MATCH_PORT_CTRL_IDX) begin
                // upper two bits stay zero
                l4_match_port_ctrl_reg <= merge16(l4_match_port_ctrl_reg, wdata_reg, wstrb_reg)
                                          & ltic_pkg::L4_MATCH_WR_MASK; // see [R17]
            end
            if (awaddr_reg[9:2] == ltic_pkg::TAG_INSERT_CTRL_IDX) begin
                // all 16 bits stored, bit 7 included
                tag_insert_ctrl_reg <= merge16(tag_insert_ctrl_reg, wdata_reg, wstrb_reg); // see [R16]
            end
        end
    end

    // ========================================================
    // read channel
    assign rd_fire = s_axi_arvalid_in & s_axi_arready_out;
    assign sec_rd_clear = rd_fire & (s_axi_araddr_in[9:2] == ltic_pkg::SEC_STATUS_IDX);

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= ltic_pkg::RESP_OKAY;
        end else begin
            s_axi_arready_out <= 1'b0;
            if (rd_fire) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rresp_out <= ltic_pkg::RESP_OKAY;
                case (s_axi_araddr_in[9:2])
                    ltic_pkg::L4_MATCH_PORT_CTRL_IDX:
                        s_axi_rdata_out <= {16'h0000, l4_match_port_ctrl_reg};
                    ltic_pkg::TAG_INSERT_CTRL_IDX:
                        s_axi_rdata_out <= {16'h0000, tag_insert_ctrl_reg};
                    ltic_pkg::SEC_STATUS_IDX:
                        s_axi_rdata_out <= {24'h00_0000, sec_flag_reg, 2'b00}; // see [R15]
                    default: begin
                        s_axi_rdata_out <= 32'h0000_0000;
                        s_axi_rresp_out <= ltic_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid_out & s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end else if (s_axi_arvalid_in & ~s_axi_rvalid_out & ~s_axi_arready_out) begin
                s_axi_arready_out <= 1'b1;
            end
        end
    end

    // ========================================================
    // security violation flags, set wins over read clear
    assign sec_set = violation_in |
                     (addr_change_in & {6{tag_insert_ctrl_reg[ltic_pkg::ADDR_CHG_BIT]}}); // see [R4]

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sec_flag_reg <= 6'h00;
        end else if (sec_rd_clear) begin
            sec_flag_reg <= sec_set; // see [R15]
        end else begin
            sec_flag_reg <= sec_flag_reg | sec_set; // see [R15]
        end
    end

    // flag output mirrors the status flops
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            security_violation_flag_out <= 6'h00;
        end else begin
            security_violation_flag_out <= sec_flag_reg;
        end
    end

    // ========================================================
    // per-frame decision
    ltic_decide u_decide (
        .clk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .frm_valid_in(frm_valid_in),
        .frm_port_in(frm_port_in),
        .frm_class_in(frm_class_in),
        .frm_has_l3_l4_in(frm_has_l3_l4_in),
        .typ_match_in(typ_match_in),
        .prot_match_in(prot_match_in),
        .dst_match_in(dst_match_in),
        .src_match_in(src_match_in),
        .dst_queue_in(dst_queue_in),
        .src_queue_in(src_queue_in),
        .l4_ctrl_in(l4_match_port_ctrl_reg),
        .tag_ctrl_in(tag_insert_ctrl_reg),
        .dec_valid_out(dec_valid_out),
        .dec_tag_out(dec_tag_out),
        .dec_l4_match_out(dec_l4_match_out),
        .dec_use_l3_out(dec_use_l3_out),
        .dec_prio_valid_out(dec_prio_valid_out),
        .dec_queue_out(dec_queue_out)
    );
endmodule // ltic_top

// ==== sim/ltic_frame_src.sv ====
// ltic_frame_src: parser-side model handing frame facts to the block.
// assumes the bench calls send right after a rising edge.
`timescale 1ns/1ps
module ltic_frame_src (
    input wire logic mclk_in,
    output logic frm_valid_out,
    output logic [2:0] frm_port_out,
    output logic [2:0] frm_class_out,
    output logic [4:0] frm_flags_out,
    output logic [1:0] dst_queue_out,
    output logic [1:0] src_queue_out
);
    // ========================================
    // one-cycle strobe, flags and class inverted outside it; port and queues held
    initial begin
        frm_valid_out = 1'h0;
        frm_port_out = 3'h0;
        frm_class_out = 3'h0;
        frm_flags_out = 5'h00;
        dst_queue_out = 2'h0;
        src_queue_out = 2'h0;
    end
    task automatic send(input logic [2:0] p, input logic [2:0] c, input logic [4:0] f,
                        input logic [1:0] dq, input logic [1:0] sq);
        @(posedge mclk_in);
        frm_valid_out <= 1'h1;
        frm_port_out <= p;
        frm_class_out <= c;
        frm_flags_out <= f;
        dst_queue_out <= dq;
        src_queue_out <= sq;
        @(posedge mclk_in);
        frm_valid_out <= 1'h0;
        frm_flags_out <= ~f;
        frm_class_out <= ~c;
        #1;
    endtask
endmodule // ltic_frame_src

// ==== sim/ltic_sva.sv ====
// ltic_sva: port-level checks of the decision, status and write-address ready outputs of ltic_top.
// assumes binding into ltic_top, one clock domain, reset low-active.
`timescale 1ns/1ps
module ltic_sva (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic frm_valid_in,
    input wire logic [2:0] frm_port_in,
    input wire logic frm_has_l3_l4_in,
    input wire logic dst_match_in,
    input wire logic src_match_in,
    input wire logic [5:0] violation_in,
    input wire logic s_axi_awready_out,
    input wire logic dec_valid_out,
    input wire logic dec_tag_out,
    input wire logic dec_l4_match_out,
    input wire logic dec_use_l3_out,
    input wire logic dec_prio_valid_out,
    input wire logic [5:0] security_violation_flag_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // ========================================
    // frame decision sequences
    sequence frame_seen;
        frm_valid_in;
    endsequence
    sequence no_l4_hit;
        frm_valid_in && !dst_match_in && !src_match_in;
    endsequence
    dec_pulse_a:
        assert property (frame_seen |=> dec_valid_out) else $error("decision missing");
    dec_idle_a:
        assert property (!frm_valid_in |=> !dec_valid_out && !dec_tag_out && !dec_prio_valid_out)
        else $error("decision without frame");
    l4_nohit_a:
        assert property (no_l4_hit |=> !dec_l4_match_out && !dec_prio_valid_out)
        else $error("l4 match without filter hit");
    prio_hit_a:
        assert property (dec_prio_valid_out |-> dec_l4_match_out) else $error("prio without hit");
    port_range_a:
        assert property (frame_seen ##0 (frm_port_in > 3'h5) |=> !dec_use_l3_out && !dec_prio_valid_out)
        else $error("port above five took effect");
    l3_need_a:
        assert property (frm_valid_in && !frm_has_l3_l4_in |=> !dec_use_l3_out)
        else $error("l3 select without both headers");
    l3_excl_a:
        assert property (dec_use_l3_out |-> !dec_prio_valid_out) else $error("l3 chosen yet l4 prio");
    viol_latch_a:
        assert property ((violation_in != 6'h00) |-> ##2
            ((security_violation_flag_out & $past(violation_in, 2)) == $past(violation_in, 2)))
        else $error("violation not latched");
    aw_pulse_a:
        assert property (s_axi_awready_out |=> !s_axi_awready_out) else $error("awready too long");
endmodule // ltic_sva

bind ltic_top ltic_sva ltic_sva_inst (.*);

// ==== sim/ltic_tb_top.sv ====
// ltic_tb_top: self-checking bench for ltic_top.
// assumes ltic_pkg compiled first and the checker bound by its own file.
`timescale 1ns/1ps
module ltic_tb_top;
    localparam logic [9:0] A_L4 = ltic_pkg::L4_MATCH_PORT_CTRL_ADDR;
    localparam logic [9:0] A_TG = ltic_pkg::TAG_INSERT_CTRL_ADDR;
    localparam logic [9:0] A_SE = ltic_pkg::SEC_STATUS_ADDR;
    logic mclk_in, rst_n_in, s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
    logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in;
    logic s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in, frm_valid_in;
    logic [9:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rdat;
    logic [3:0] s_axi_wstrb_in;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, dst_queue_in, src_queue_in, dec_queue_out;
    logic [1:0] wresp, rresp;
    logic [2:0] frm_port_in, frm_class_in;
    logic [4:0] flags;
    logic frm_has_l3_l4_in, typ_match_in, prot_match_in, dst_match_in, src_match_in;
    logic [5:0] addr_change_in, violation_in, security_violation_flag_out;
    logic dec_valid_out, dec_tag_out, dec_l4_match_out, dec_use_l3_out, dec_prio_valid_out;
    int bad_count = 0;
    int checks_done = 0;
    assign {frm_has_l3_l4_in, typ_match_in, prot_match_in, dst_match_in, src_match_in} = flags;
    // ========================================
    // design and parser model
    ltic_top ltic_top_inst (.*);
    ltic_frame_src ltic_frame_src_inst (.mclk_in(mclk_in), .frm_valid_out(frm_valid_in),
        .frm_port_out(frm_port_in), .frm_class_out(frm_class_in), .frm_flags_out(flags),
        .dst_queue_out(dst_queue_in), .src_queue_out(src_queue_in));
    initial begin
        mclk_in = 1'h0;
        forever #25 mclk_in = ~mclk_in;
    end
    // ========================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    // bus tasks wait for the answer; only the watchdog ends a hang
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'h1;
        s_axi_wvalid_in <= 1'h1;
        s_axi_bready_in <= 1'h1;
        do begin
            @(posedge mclk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
        end while (s_axi_bvalid_out !== 1'h1);
        wresp = s_axi_bresp_out;
        s_axi_bready_in <= 1'h0;
    endtask
    task automatic rd(input logic [9:0] a);
        @(posedge mclk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'h1;
        s_axi_rready_in <= 1'h1;
        do begin
            @(posedge mclk_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
        end while (s_axi_rvalid_out !== 1'h1);
        rdat = s_axi_rdata_out;
        rresp = s_axi_rresp_out;
        s_axi_rready_in <= 1'h0;
    endtask
    task automatic pulse(input logic ac, input logic [5:0] v);
        @(posedge mclk_in);
        if (ac) addr_change_in <= v;
        else violation_in <= v;
        @(posedge mclk_in);
        addr_change_in <= 6'h00;
        violation_in <= 6'h00;
        repeat (3) @(posedge mclk_in);
    endtask
    // ========================================
    // scenarios
    task automatic t_regs;
        rd(A_L4);
        chk("l4 reset", 32'h0000_0000, rdat);
        rd(A_TG);
        chk("tag reset", 32'h0000_01ff, rdat);
        rd(10'h3fc);
        chk("unmapped resp", ltic_pkg::RESP_SLVERR, {30'h0, rresp});
        wr(10'h3fc, 32'h0000_ffff);
        chk("unmapped wresp", ltic_pkg::RESP_SLVERR, {30'h0, wresp});
        wr(A_L4, 32'hffff_ffff);
        rd(A_L4);
        chk("l4 reserved", 32'h0000_3fff, rdat);
        s_axi_wstrb_in <= 4'h2;
        wr(A_L4, 32'h0000_0000);
        s_axi_wstrb_in <= 4'hf;
        rd(A_L4);
        chk("l4 lane", 32'h0000_00ff, rdat);
        wr(A_TG, 32'h0000_0080);
        rd(A_TG);
        chk("tag bit7", 32'h0000_0080, rdat);
        ltic_frame_src_inst.send(3'h0, 3'h0, 5'h00, 2'h0, 2'h0);
        chk("bit7 no tag", 32'h0, {31'h0, dec_tag_out});
    endtask
    task automatic t_tag;
        int b[8] = '{8, 6, 5, 4, 3, 2, 1, 0};
        logic [2:0] c[8] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h1, 3'h1, 3'h4, 3'h0};
        logic [4:0] f[8] = '{5'h00, 5'h00, 5'h00, 5'h08, 5'h04, 5'h02, 5'h00, 5'h00};
        wr(A_L4, 32'h0000_1000);
        for (int i = 0; i < 8; i++) begin
            for (int m = 0; m < 2; m++) begin
                wr(A_TG, m ? (32'h0000_01ff & ~(32'h1 << b[i])) : (32'h1 << b[i]));
                ltic_frame_src_inst.send(3'h0, c[i], f[i], 2'h0, 2'h0);
                chk("tag", {31'h0, m == 0},
                    {31'h0, dec_tag_out});
            end
        end
    endtask
    task automatic t_l4;
        logic e;
        for (int md = 0; md < 4; md++) begin
            wr(A_L4, (md << 12) | 32'h1);
            for (int h = 1; h < 4; h++) begin
                e = md == 1 ? h[1] : md == 2 ? h[0] : md == 3;
                ltic_frame_src_inst.send(3'h0, 3'h1, 5'(h), 2'h1, 2'h2);
                chk("l4 match", {31'h0, e}, {31'h0, dec_l4_match_out});
                chk("prio", {31'h0, e}, {31'h0, dec_prio_valid_out});
                chk("queue", !e ? 0 : (md == 2 || !h[1]) ? 2 : 1,
                    {30'h0, dec_queue_out});
            end
        end
    endtask
    task automatic t_port;
        logic pe;
        for (int p = 0; p < 6; p++) begin
            for (int s = 0; s < 2; s++) begin
                wr(A_L4, s ? (32'h103f | (32'h40 << p)) : (32'h1000 | (32'h1 << p)));
                for (int q = 0; q < 7; q++) begin
                    ltic_frame_src_inst.send(3'(q), 3'h1, 5'h12, 2'h3, 2'h0);
                    pe = s ? (q != p && q < 6) : q == p;
                    chk("use l3", {31'h0, s && q == p}, {31'h0, dec_use_l3_out});
                    chk("port prio", {31'h0, pe}, {31'h0, dec_prio_valid_out});
                    chk("port queue", pe ? 3 : 0, {30'h0, dec_queue_out});
                end
            end
        end
    endtask
    task automatic t_sec;
        wr(A_TG, 32'h0000_01ff);
        pulse(1'h1, 6'h02);
        rd(A_SE);
        chk("no include", 32'h0, rdat & 32'h0000_00fc);
        wr(A_TG, 32'h0000_03ff);
        pulse(1'h1, 6'h02);
        chk("flag out", 32'h2, {26'h0, security_violation_flag_out});
        rd(A_SE);
        chk("include", 32'h8, rdat & 32'h0000_00fc);
        rd(A_SE);
        chk("read clear", 32'h0, rdat & 32'h0000_00fc);
        pulse(1'h0, 6'h10);
        rd(A_SE);
        chk("violation", 32'h40, rdat & 32'h0000_00fc);
    endtask
    task automatic results;
        if (bad_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ========================================
    // main sequence and watchdog
    initial begin
        rst_n_in = 1'h0;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
        {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
        s_axi_awaddr_in = 10'h000;
        s_axi_araddr_in = 10'h000;
        s_axi_wdata_in = 32'h0000_0000;
        s_axi_wstrb_in = 4'hf;
        addr_change_in = 6'h00;
        violation_in = 6'h00;
        repeat (16) @(posedge mclk_in);
        rst_n_in <= 1'h1;
        t_regs();
        t_tag();
        t_l4();
        t_port();
        t_sec();
        results();
    end
    initial begin
        repeat (20000) @(posedge mclk_in);
        bad_count++;
        results();
    end
endmodule // ltic_tb_top
